// File: logic/ext_mem_map.vh
// register offsets, fields, reset values and timing constants of the external memory bus interface
`ifndef EXT_MEM_MAP_VH
`define EXT_MEM_MAP_VH

// ************************************************
// register byte offsets
// ************************************************
`define CTRL_OFFSET 12'h000
`define SECTOR_OFFSET 12'h004
`define MASK_OFFSET 12'h008
`define PORT_OFFSET 12'h00c
`define STATUS_OFFSET 12'h010

// ************************************************
// control fields
// ************************************************
`define CTRL_ENABLE_BIT 0
`define CTRL_KEEPER_BIT 1
`define CTRL_LOWER_WAIT_LSB 2
`define CTRL_UPPER_WAIT_LSB 4
`define CTRL_RESET 6'h00

// ************************************************
// address map and timing
// ************************************************
`define INTERNAL_TOP 16'h21ff
`define SECTOR_RESET 16'h2200
`define BASE_PERIODS 3'h4

`endif

// File: logic/ext_mem_bus.v
// external data-memory bus interface with apb register slave
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "ext_mem_map.vh"

module ext_mem_bus (
    input wire sys_clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire acc_req,
    input wire acc_write,
    input wire [15:0] acc_addr,
    input wire [7:0] acc_wdata,
    input wire next_is_mem,
    output reg acc_busy,
    output reg acc_done,
    output reg [7:0] acc_rdata,
    output reg [7:0] ad_out,
    output reg [7:0] ad_oe,
    output reg [7:0] ad_pullup,
    input wire [7:0] ad_in,
    output reg [7:0] addr_hi_out,
    output reg [7:0] addr_hi_oe,
    output reg latch_strobe,
    output reg read_strobe_n,
    output reg write_strobe_n
);

    // ************************************************
    // state
    // ************************************************
    localparam ST_IDLE = 4'b0001;
    localparam ST_ADDR = 4'b0010;
    localparam ST_DATA = 4'b0100;
    localparam ST_LAST = 4'b1000;

    reg [5:0] ctrl_q;
    reg [15:0] sector_q;
    reg [2:0] mask_q;
    reg [7:0] port_out_q;
    reg [7:0] port_dir_q;
    reg [3:0] state_q;
    reg [2:0] count_q;
    reg [2:0] last_q;
    reg ext_q;
    reg write_q;
    reg [15:0] addr_q;
    reg [7:0] wdata_q;
    reg [7:0] keep_q;
    reg err_q;

    wire enable = ctrl_q[`CTRL_ENABLE_BIT];
    wire keeper = ctrl_q[`CTRL_KEEPER_BIT];
    wire [1:0] lower_wait = ctrl_q[`CTRL_LOWER_WAIT_LSB +: 2];
    wire [1:0] upper_wait = ctrl_q[`CTRL_UPPER_WAIT_LSB +: 2];
    wire is_ext = acc_addr > `INTERNAL_TOP;
    wire [1:0] wait_sel = (acc_addr >= sector_q) ? upper_wait : lower_wait;
    wire start = acc_req && enable && (state_q == ST_IDLE);
    wire apb_go = psel && penable && !pready;

    // ************************************************
    // access length from the selected wait setting
    // ************************************************
    reg [2:0] periods_d;
    always @* begin
        case (wait_sel)
            2'b00: periods_d = `BASE_PERIODS;
            2'b01: periods_d = `BASE_PERIODS + 3'h1;
            2'b10: periods_d = `BASE_PERIODS + 3'h2;
            2'b11: periods_d = `BASE_PERIODS + 3'h3;
            default: periods_d = `BASE_PERIODS;
        endcase
    end

    // ************************************************
    // apb register slave, one wait state
    // ************************************************
    reg [31:0] rd_d;
    reg hit;
    always @* begin
        rd_d = 32'h00000000;
        hit = 1'b1;
        case (paddr)
            `CTRL_OFFSET: rd_d = {26'h0, ctrl_q};
            `SECTOR_OFFSET: rd_d = {16'h0, sector_q};
            `MASK_OFFSET: rd_d = {29'h0, mask_q};
            `PORT_OFFSET: rd_d = {16'h0, port_dir_q, port_out_q};
            `STATUS_OFFSET: rd_d = {28'h0, err_q, ext_q, acc_busy, enable};
            default: hit = 1'b0;
        endcase
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `CTRL_RESET;
            sector_q <= `SECTOR_RESET;
            mask_q <= 3'h0;
            port_out_q <= 8'h00;
            port_dir_q <= 8'h00;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_go;
            pslverr <= apb_go && !hit;
            prdata <= (apb_go && !pwrite) ? rd_d : 32'h00000000;
            if (apb_go && pwrite) begin
                case (paddr)
                    `CTRL_OFFSET: ctrl_q <= pwdata[5:0];
                    `SECTOR_OFFSET: sector_q <= pwdata[15:0];
                    `MASK_OFFSET: mask_q <= pwdata[2:0];
                    `PORT_OFFSET: begin
                        port_out_q <= pwdata[7:0];
                        port_dir_q <= pwdata[15:8];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ************************************************
    // bus cycle sequencer
    // ************************************************
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            count_q <= 3'h0;
            last_q <= 3'h0;
            ext_q <= 1'b0;
            write_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            acc_busy <= 1'b0;
            acc_done <= 1'b0;
            latch_strobe <= 1'b0;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end else begin
            acc_done <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_ADDR;
                        addr_q <= acc_addr;
                        wdata_q <= acc_wdata;
                        write_q <= acc_write;
                        ext_q <= is_ext;
                        last_q <= periods_d;
                        count_q <= 3'h1;
                        acc_busy <= 1'b1;
                        latch_strobe <= 1'b1;
                    end
                end
                ST_ADDR: begin
                    latch_strobe <= 1'b0;
                    count_q <= count_q + 3'h1;
                    state_q <= ST_DATA;
                    if (ext_q && write_q)
                        write_strobe_n <= 1'b0;
                    if (ext_q && !write_q)
                        read_strobe_n <= 1'b0;
                end
                ST_DATA: begin
                    count_q <= count_q + 3'h1;
                    if (count_q + 3'h1 == last_q) begin
                        state_q <= ST_LAST;
                        read_strobe_n <= 1'b1;
                        write_strobe_n <= 1'b1;
                        latch_strobe <= next_is_mem;
                    end
                end
                ST_LAST: begin
                    latch_strobe <= 1'b0;
                    acc_busy <= 1'b0;
                    acc_done <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ************************************************
    // read data capture
    // ************************************************
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_rdata <= 8'h00;
        end else if (state_q == ST_DATA && count_q + 3'h1 == last_q && !write_q) begin
            // taken while the read strobe is still low
            acc_rdata <= ad_in;
        end
    end

    // ************************************************
    // sticky error for external addresses while disabled
    // ************************************************
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            err_q <= 1'b0;
        end else if (acc_req && !enable && acc_addr > `INTERNAL_TOP) begin
            err_q <= 1'b1;
        end
    end

    // ************************************************
    // high address lines
    // ************************************************
    reg [7:0] hi_out_d;
    reg [7:0] hi_oe_d;
    integer i;
    always @* begin
        hi_out_d = port_out_q;
        hi_oe_d = port_dir_q;
        if (enable) begin
            hi_oe_d = 8'hff;
            hi_out_d = addr_q[15:8];
            // the top mask_q lines go back to the port register
            for (i = 0; i < 7; i = i + 1) begin
                if (mask_q > i[2:0]) begin
                    hi_out_d[7 - i] = port_out_q[7 - i];
                    hi_oe_d[7 - i] = port_dir_q[7 - i];
                end
            end
        end
    end

    // ************************************************
    // muxed address/data lines
    // ************************************************
    reg [7:0] ad_out_d;
    reg [7:0] ad_oe_d;
    reg [7:0] keep_d;
    always @* begin
        ad_out_d = ad_out;
        ad_oe_d = ad_oe;
        keep_d = keep_q;
        if (!enable) begin
            ad_out_d = port_out_q;
            ad_oe_d = port_dir_q;
        end else if (start) begin
            ad_out_d = acc_addr[7:0];
            ad_oe_d = 8'hff;
            keep_d = acc_addr[7:0];
        end else if (state_q == ST_ADDR && write_q) begin
            // address held while the latch closes, data follows a cycle later
            ad_oe_d = 8'hff;
        end else if (state_q == ST_DATA && write_q) begin
            ad_out_d = wdata_q;
            ad_oe_d = 8'hff;
            keep_d = wdata_q;
        end else begin
            ad_out_d = keep_q;
            ad_oe_d = keeper ? 8'hff : 8'h00;
        end
    end

    // ************************************************
    // pull-up enables
    // ************************************************
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ad_pullup <= 8'h00;
        end else begin
            ad_pullup <= port_out_q;
        end
    end

    // ************************************************
    // pin registers
    // ************************************************
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ad_out <= 8'h00;
            ad_oe <= 8'h00;
            addr_hi_out <= 8'h00;
            addr_hi_oe <= 8'h00;
            keep_q <= 8'h00;
        end else begin
            ad_out <= ad_out_d;
            ad_oe <= ad_oe_d;
            addr_hi_out <= hi_out_d;
            addr_hi_oe <= hi_oe_d;
            keep_q <= keep_d;
        end
    end

endmodule // ext_mem_bus

// File: testbench/ext_mem_bus_monitor.sv
// assertion checker for the external memory bus interface
`timescale 1ns/10ps
module ext_mem_monitor (
    input wire sys_clk,
    input wire reset_n,
    input wire [15:0] acc_addr,
    input wire acc_busy,
    input wire acc_done,
    input wire latch_strobe,
    input wire read_strobe_n,
    input wire write_strobe_n
);
    reg int_q;
    wire strb = !read_strobe_n || !write_strobe_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // remembers whether the access taken last was internal
    always @(posedge sys_clk or negedge reset_n)
        if (!reset_n) int_q <= 1'h0;
        else if (!acc_busy) int_q <= acc_addr <= 16'h21ff;
    a_strobe_after_latch: assert property (($fell(read_strobe_n) || $fell(write_strobe_n)) |-> $past(latch_strobe))
        else $error("strobe fell without latch pulse");
    a_latch_low_xfer: assert property (strb |-> !latch_strobe) else $error("latch high in transfer");
    a_strobe_busy: assert property (strb |-> acc_busy) else $error("strobe outside access");
    a_one_strobe: assert property (!(!read_strobe_n && !write_strobe_n)) else $error("both strobes low");
    a_internal_quiet: assert property (acc_busy && int_q |-> !strb) else $error("strobe on internal");
    a_latch_opens: assert property ($rose(acc_busy) |-> latch_strobe) else $error("no opening latch");
    a_access_len: assert property ($rose(acc_busy) |-> acc_busy [*4] ##[1:4] acc_done)
        else $error("access length out of range");
    a_done_single: assert property (acc_done |-> !acc_busy ##1 !acc_done) else $error("done not a pulse");
endmodule // ext_mem_monitor
bind ext_mem_bus ext_mem_monitor mon (.*);

// File: testbench/ext_sram_model.sv
// external byte memory behind a transparent address latch
`timescale 1ns/10ps
module ext_sram_model (
    input wire latch_strobe,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire [7:0] ad_out,
    input wire [7:0] ad_oe,
    input wire [7:0] ad_pullup,
    output wire [7:0] ad_in
);
    reg [7:0] mem [0:255];
    reg [7:0] addr_q;
    // no clock here: latch and write follow the strobes alone
    // address taken as the latch closes, data as the write strobe rises
    always @(negedge latch_strobe) addr_q = ad_out;
    always @(posedge write_strobe_n) mem[addr_q] = ad_out;
    // released bits show the pull-up or the inverse of the last value
    assign ad_in = !read_strobe_n ? mem[addr_q] : (ad_oe & ad_out) | (~ad_oe & (ad_pullup | ~ad_out));
endmodule // ext_sram_model

// File: testbench/test_ext_mem_bus.sv
// self-checking bench for the external memory bus interface
`timescale 1ns/10ps
module test_ext_mem_bus;
    logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, err_q, acc_req, acc_write, next_is_mem;
    logic acc_busy, acc_done, latch_strobe, read_strobe_n, write_strobe_n;
    logic [11:0] paddr;
    logic [15:0] acc_addr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [7:0] acc_wdata, acc_rdata, ad_out, ad_oe, ad_pullup, ad_in, addr_hi_out, addr_hi_oe, hi_q;
    int n_errors = 0, compares = 0, n, lat, stb;
    ext_mem_bus uut (.*);
    ext_sram_model mem (.*);
    task automatic chk(input string s, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        {rd_q, err_q} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    // counts periods up to done, latch-high periods and strobe-low periods
    task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d, input int en, el);
        @(posedge sys_clk);
        {acc_req, acc_addr, acc_write, acc_wdata} <= {1'h1, a, w, d};
        {n, lat, stb} = '0;
        do begin
            @(posedge sys_clk);
            acc_req <= 1'h0;
            #1;
            n++;
            lat += latch_strobe;
            stb += !read_strobe_n || !write_strobe_n;
            if (n == 2) hi_q = addr_hi_out;
        end while (acc_done !== 1'h1 && n < 20);
        chk("access periods", n, en);
        chk("latch pulses", lat, el);
    endtask
    initial forever #10 sys_clk = ~sys_clk;
    initial begin
        #400000;
        n_errors++;
        wrap_up;
    end
    initial begin
        sys_clk = 1'h0;
        {reset_n, psel, penable, pwrite, paddr, pwdata, acc_req, acc_write, acc_addr, acc_wdata, next_is_mem} = '0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'h1;
        chk("pullup at reset", ad_pullup, 8'h00);
        apb(1'h0, 12'h004, 32'h0);
        chk("sector reset", rd_q, 32'h2200);
        apb(1'h0, 12'h0f0, 32'h0);
        chk("unmapped error", err_q, 1'h1);
        acc(16'h3000, 1'h1, 8'h00, 20, 0);
        apb(1'h1, 12'h00c, 32'ha5);
        apb(1'h0, 12'h010, 32'h0);
        chk("disabled ext flag", rd_q[3], 1'h1);
        chk("pullup from port", ad_pullup, 8'ha5);
        apb(1'h1, 12'h004, 32'h8000);
        for (int w = 0; w < 4; w++) begin
            apb(1'h1, 12'h000, 1 | w << 2 | (3 - w) << 4);
            next_is_mem <= w[0];
            acc(16'h2300 + w, 1'h1, 8'h40 + w, 5 + w, 1 + w[0]);
            chk("high address", hi_q, 8'h23);
            acc(16'h8110 + w, 1'h1, 8'h50 + w, 8 - w, 1 + w[0]);
            acc(16'h2300 + w, 1'h0, 8'h00, 5 + w, 1 + w[0]);
            chk("read back", acc_rdata, 8'h40 + w);
        end
        apb(1'h1, 12'h000, 32'h1);
        acc(16'h0100, 1'h1, 8'h77, 5, 2);
        chk("internal strobes", stb, 0);
        apb(1'h1, 12'h000, 32'h3);
        acc(16'h0100, 1'h1, 8'h77, 5, 2);
        chk("keeper drive", {ad_oe, ad_out}, 16'hff77);
        apb(1'h1, 12'h00c, 32'hff00);
        apb(1'h1, 12'h008, 32'h2);
        acc(16'hc100, 1'h0, 8'h00, 5, 2);
        chk("masked high", hi_q, 8'h01);
        chk("aliased data", acc_rdata, 8'h40);
        wrap_up;
    end
endmodule // test_ext_mem_bus
